// ==== hw/uart_frac.v ====
// Function
// [R1] Transmit and receive enabled after reset
// [R2] Software disables port before reconfiguring
// [R3] Disable finishes the current character first
// [R4] Start, data LSB first, parity, stops
// [R5] 5-8 bits, parity kinds, 1/2 stops
// [R6] Divisor: 16-bit integer, 6-bit fraction
// [R7] Sixteen-x tick; tx divides by sixteen
// [R8] Divisors take effect on line control write
// [R9] 16-entry tx FIFO, 12-bit rx FIFO
// [R10] Frames continue while tx FIFO nonempty
// [R11] Busy until FIFO empty and shifter done
// [R12] Start bit checked on eighth tick
// [R13] Data sampled every sixteenth tick
// [R14] Framing error on low stop bit
// [R15] Rx entries carry overrun/parity/framing/break
// [R16] Data read 12 bits, write 8 bits
// [R17] FIFOs one deep until FIFO enable
// [R18] Selectable thresholds, reset to half
// [R19] Latched events ORed into one request
// [R20] Mask gates events; raw always readable
// [R21] Clear register clears written events
// [R22] Receive timeout after 32 idle bits
// [R23] Overrun when rx FIFO full; char lost
// [R24] Break after line low a full character
// [R25] Loopback feeds transmitter into receiver
// [R26] Fractional accumulator averages tick period
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`include "uart_frac_regs.vh"
module uart_frac #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire serial_receive_line,
  output reg serial_transmit_line,
  output reg irq
);
  reg [15:0] ibrd_q;
  reg [5:0] fbrd_q;
  reg [7:0] lcrh_q;
  reg [15:0] act_int_q;
  reg [5:0] act_frac_q;
  reg [9:0] ctl_q;
  reg [5:0] ifls_q;
  reg [6:0] im_q;
  reg [6:0] ris_q;
  reg [3:0] rsr_q;
  wire en = ctl_q[`CTL_EN];
  wire fifo_enable_bit = lcrh_q[`LCRH_FEN];
  wire [1:0] wlen = lcrh_q[`LCRH_WLEN+1:`LCRH_WLEN];
  wire [3:0] nbits = 4'h5 + {2'b00, wlen};
  // Fractional 16x tick
  reg [15:0] bcnt_q;
  reg [6:0] facc_q;
  reg tick_q;
  wire [6:0] facc_sum = facc_q + {1'b0, act_frac_q};
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bcnt_q <= 16'h0;
      facc_q <= 7'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (act_int_q != 16'h0)
      begin
        if (bcnt_q == 16'h0)
        begin
          tick_q <= 1'b1; // [R7]
          facc_q <= {1'b0, facc_sum[5:0]}; // [R26]
          bcnt_q <= act_int_q - 16'h1 + {15'h0, facc_sum[6]}; // [R6]
        end
        else
          bcnt_q <= bcnt_q - 16'h1;
      end
    end
  end
  // Transmit FIFO
  reg [7:0] tmem [0:DEPTH-1];
  reg [AW-1:0] twp_q, trp_q;
  reg [AW:0] tcnt_q;
  wire [AW:0] tcap = fifo_enable_bit ? DEPTH[AW:0] : {{AW{1'b0}}, 1'b1}; // [R17]
  wire tfull = tcnt_q >= tcap;
  wire tpush = wr && addr == `A_DATA && !tfull; // [R16]
  wire tpop;
  always @(posedge sys_clk)
  begin
    if (tpush)
      tmem[twp_q] <= wdata[7:0]; // [R9]
  end
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      twp_q <= {AW{1'b0}};
      trp_q <= {AW{1'b0}};
      tcnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (tpush)
        twp_q <= twp_q + 1'b1;
      if (tpop)
        trp_q <= trp_q + 1'b1;
      tcnt_q <= tcnt_q + {{AW{1'b0}}, tpush} - {{AW{1'b0}}, tpop};
    end
  end
  // Transmitter
  localparam T_IDLE = 2'd0;
  localparam T_SHIFT = 2'd1;
  reg [1:0] tst_q;
  reg [11:0] tsh_q;
  reg [3:0] tleft_q;
  reg [3:0] tdiv_q;
  reg txo_q;
  wire [7:0] thead = tmem[trp_q];
  wire [7:0] tmask = 8'hff >> (4'h8 - nbits);
  wire tpar = lcrh_q[`LCRH_SPS] ? ~lcrh_q[`LCRH_EPS] : (^(thead & tmask)) ^ ~lcrh_q[`LCRH_EPS];
  assign tpop = tst_q == T_IDLE && tcnt_q != 0 && en && ctl_q[`CTL_TXE] && tick_q; // [R10]
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tst_q <= T_IDLE;
      tsh_q <= 12'hfff;
      tleft_q <= 4'h0;
      tdiv_q <= 4'h0;
      txo_q <= 1'b1;
    end
    else
      case (tst_q)
        T_IDLE:
        begin
          txo_q <= 1'b1;
          if (tpop)
          begin
            // Data, parity, stops from bit 0 up, LSB first; start bit driven directly
            tsh_q <= ({4'h0, thead & tmask} | ({11'h0, lcrh_q[`LCRH_PEN] & tpar} << nbits)
              | (12'hfff << (nbits + {3'h0, lcrh_q[`LCRH_PEN]})) ); // [R4] [R5]
            tleft_q <= nbits + {3'h0, lcrh_q[`LCRH_PEN]} + {3'h0, lcrh_q[`LCRH_STP2]} + 4'h1;
            txo_q <= 1'b0;
            tdiv_q <= 4'h0;
            tst_q <= T_SHIFT;
          end
        end
        T_SHIFT:
          if (tick_q)
          begin
            tdiv_q <= tdiv_q + 4'h1;
            if (tdiv_q == 4'hf) // [R7]
            begin
              // Runs to the end even if disabled
              if (tleft_q == 4'h0) // [R3]
                tst_q <= T_IDLE;
              else
              begin
                txo_q <= tsh_q[0];
                tsh_q <= {1'b1, tsh_q[11:1]};
                tleft_q <= tleft_q - 4'h1;
              end
            end
          end
        default: tst_q <= T_IDLE;
      endcase
  end
  wire busy = tcnt_q != 0 || tst_q != T_IDLE; // [R11]
  // Receive line sync and loopback
  reg [1:0] rsync_q;
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rsync_q <= 2'h3;
    else
      rsync_q <= {rsync_q[0], serial_receive_line};
  end
  wire rxin = ctl_q[`CTL_LBE] ? txo_q : rsync_q[1]; // [R25]
  // Receiver
  localparam R_IDLE = 2'd0;
  localparam R_START = 2'd1;
  localparam R_BITS = 2'd2;
  reg [1:0] rst_q;
  reg [3:0] rtk_q;
  reg [3:0] ridx_q;
  reg [9:0] rsh_q;
  reg push_q;
  reg [11:0] pword_q;
  reg [3:0] bkcnt_q;
  wire [3:0] rtotal = nbits + {3'h0, lcrh_q[`LCRH_PEN]} + 4'h1;
  wire [9:0] rfull_sh = {rxin, rsh_q[9:1]} >> (4'ha - rtotal);
  wire [7:0] rdat = rfull_sh[7:0] & tmask;
  wire rpbit = rfull_sh[nbits];
  wire rpar_exp = lcrh_q[`LCRH_SPS] ? ~lcrh_q[`LCRH_EPS] : (^rdat) ^ ~lcrh_q[`LCRH_EPS];
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_q <= R_IDLE;
      rtk_q <= 4'h0;
      ridx_q <= 4'h0;
      rsh_q <= 10'h0;
      push_q <= 1'b0;
      pword_q <= 12'h0;
      bkcnt_q <= 4'h0;
    end
    else
    begin
      push_q <= 1'b0;
      if (tick_q)
        case (rst_q)
          R_IDLE:
            if (!rxin && en && ctl_q[`CTL_RXE])
            begin
              rst_q <= R_START;
              rtk_q <= 4'h0;
            end
          R_START:
          begin
            rtk_q <= rtk_q + 4'h1;
            if (rtk_q == 4'h7) // [R12]
            begin
              rst_q <= rxin ? R_IDLE : R_BITS;
              rtk_q <= 4'h0;
              ridx_q <= 4'h0;
              bkcnt_q <= 4'h0;
            end
          end
          R_BITS:
          begin
            rtk_q <= rtk_q + 4'h1;
            if (rtk_q == 4'hf) // [R13]
            begin
              if (ridx_q == rtotal - 4'h1)
              begin
                rst_q <= R_IDLE;
                push_q <= 1'b1;
                // Break, parity, framing in upper bits; overrun added at push
                pword_q <= {1'b0, (bkcnt_q == rtotal - 4'h1) && !rxin, // [R24]
                  lcrh_q[`LCRH_PEN] && (rpbit != rpar_exp), !rxin, rdat}; // [R15] [R14]
              end
              else
              begin
                rsh_q <= {rxin, rsh_q[9:1]};
                ridx_q <= ridx_q + 4'h1;
                bkcnt_q <= bkcnt_q + {3'h0, !rxin};
              end
            end
          end
          default: rst_q <= R_IDLE;
        endcase
    end
  end
  // Receive FIFO
  reg [11:0] rmem [0:DEPTH-1];
  reg [AW-1:0] rwp_q, rrp_q;
  reg [AW:0] rcnt_q;
  wire rfull = rcnt_q >= tcap;
  wire rpush = push_q && !rfull;
  wire rpop = rd && addr == `A_DATA && rcnt_q != 0;
  reg ovr_q;
  always @(posedge sys_clk)
  begin
    if (rpush)
      rmem[rwp_q] <= {ovr_q, pword_q[10:0]};
  end
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rwp_q <= {AW{1'b0}};
      rrp_q <= {AW{1'b0}};
      rcnt_q <= {(AW+1){1'b0}};
      ovr_q <= 1'b0;
    end
    else
    begin
      if (rpush)
        rwp_q <= rwp_q + 1'b1;
      if (rpop)
        rrp_q <= rrp_q + 1'b1;
      rcnt_q <= rcnt_q + {{AW{1'b0}}, rpush} - {{AW{1'b0}}, rpop};
      if (push_q && rfull)
        ovr_q <= 1'b1; // [R23]
      else if (rpush)
        ovr_q <= 1'b0;
    end
  end
  // Receive timeout
  reg [11:0] rtcnt_q;
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rtcnt_q <= 12'h0;
    else if (rcnt_q == 0 || push_q || rst_q != R_IDLE)
      rtcnt_q <= 12'h0;
    else if (tick_q && rtcnt_q != {`RT_BITS, 4'h0})
      rtcnt_q <= rtcnt_q + 12'h1;
  end
  wire rt_hit = tick_q && rtcnt_q == {`RT_BITS, 4'h0} - 12'h1; // [R22]
  // Levels
  function [31:0] lvl;
    input [2:0] sel;
    case (sel)
      3'h0: lvl = DEPTH / 8;
      3'h1: lvl = DEPTH / 4;
      3'h2: lvl = DEPTH / 2;
      3'h3: lvl = DEPTH * 3 / 4;
      default: lvl = DEPTH * 7 / 8;
    endcase
  endfunction
  wire tx_lvl = tcnt_q <= lvl(ifls_q[2:0]); // [R18]
  wire rx_lvl = rcnt_q >= lvl(ifls_q[5:3]);
  reg tx_lvl_q, rx_lvl_q;
  wire [6:0] ev_set;
  assign ev_set[`EV_RX] = rx_lvl && !rx_lvl_q;
  assign ev_set[`EV_TX] = tx_lvl && !tx_lvl_q;
  assign ev_set[`EV_RT] = rt_hit;
  assign ev_set[`EV_FE] = rpush && pword_q[8];
  assign ev_set[`EV_PE] = rpush && pword_q[9];
  assign ev_set[`EV_BE] = rpush && pword_q[10];
  assign ev_set[`EV_OE] = push_q && rfull;
  wire [6:0] ev_clr = (wr && addr == `A_ICR) ? wdata[6:0] : 7'h0;
  wire rt_empty_clr = rpop && rcnt_q == 1;
  // Registers
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ibrd_q <= 16'h0;
      fbrd_q <= 6'h0;
      lcrh_q <= 8'h0;
      act_int_q <= 16'h0;
      act_frac_q <= 6'h0;
      ctl_q <= `CTL_RESET; // [R1]
      ifls_q <= `IFLS_RESET; // [R18]
      im_q <= 7'h0;
      ris_q <= 7'h0;
      rsr_q <= 4'h0;
      tx_lvl_q <= 1'b0;
      rx_lvl_q <= 1'b0;
      rdata <= 32'h0;
      irq <= 1'b0;
      serial_transmit_line <= 1'b1;
    end
    else
    begin
      tx_lvl_q <= tx_lvl;
      rx_lvl_q <= rx_lvl;
      // Set wins over clear
      ris_q <= ((ris_q & ~ev_clr & ~{4'h0, rt_empty_clr, 2'h0}) | ev_set); // [R19] [R21]
      irq <= |(ris_q & im_q); // [R20]
      serial_transmit_line <= txo_q;
      if (rpop)
        rsr_q <= rmem[rrp_q][11:8];
      if (wr)
        case (addr)
          `A_RSR: rsr_q <= 4'h0;
          `A_IBRD: ibrd_q <= wdata[15:0];
          `A_FBRD: fbrd_q <= wdata[5:0];
          `A_LCRH:
          begin
            lcrh_q <= wdata[7:0];
            act_int_q <= ibrd_q; // [R8]
            act_frac_q <= fbrd_q;
          end
          `A_CTL: ctl_q <= {wdata[9:7], 6'h0, wdata[0]};
          `A_IFLS: ifls_q <= wdata[5:0];
          `A_IM: im_q <= wdata[6:0];
          default: ;
        endcase
      rdata <= 32'h0;
      if (rd)
        case (addr)
          `A_DATA: rdata <= {20'h0, rcnt_q != 0 ? rmem[rrp_q] : 12'h0}; // [R16]
          `A_RSR: rdata <= {28'h0, rsr_q[3], rsr_q[2], rsr_q[1], rsr_q[0]};
          `A_FLAG: rdata <= {24'h0, tcnt_q == 0, rcnt_q >= tcap, tfull, rcnt_q == 0,
            busy, 3'h0};
          `A_IBRD: rdata <= {16'h0, ibrd_q};
          `A_FBRD: rdata <= {26'h0, fbrd_q};
          `A_LCRH: rdata <= {24'h0, lcrh_q};
          `A_CTL: rdata <= {22'h0, ctl_q};
          `A_IFLS: rdata <= {26'h0, ifls_q};
          `A_IM: rdata <= {25'h0, im_q};
          `A_RIS: rdata <= {25'h0, ris_q};
          `A_MIS: rdata <= {25'h0, ris_q & im_q}; // [R20]
          default: rdata <= 32'h0;
        endcase
    end
  end
endmodule

// ==== hw/uart_frac_regs.vh ====
`ifndef UART_FRAC_REGS_VH
`define UART_FRAC_REGS_VH
`define A_DATA 4'h0
`define A_RSR 4'h1
`define A_FLAG 4'h2
`define A_IBRD 4'h3
`define A_FBRD 4'h4
`define A_LCRH 4'h5
`define A_CTL 4'h6
`define A_IFLS 4'h7
`define A_IM 4'h8
`define A_RIS 4'h9
`define A_MIS 4'ha
`define A_ICR 4'hb
`define CTL_RESET 10'h300
`define CTL_EN 0
`define CTL_LBE 7
`define CTL_TXE 8
`define CTL_RXE 9
`define LCRH_BRK 0
`define LCRH_PEN 1
`define LCRH_EPS 2
`define LCRH_STP2 3
`define LCRH_FEN 4
`define LCRH_WLEN 5
`define LCRH_SPS 7
`define IFLS_RESET 6'h12
`define EV_RX 0
`define EV_TX 1
`define EV_RT 2
`define EV_FE 3
`define EV_PE 4
`define EV_BE 5
`define EV_OE 6
`define RT_BITS 8'h20
`endif

// ==== tb/serial_peer.sv ====
`timescale 1ns/1ns
module serial_peer #(
  parameter BIT = 32
) (
  input wire sys_clk,
  input wire serial_transmit_line,
  output reg serial_receive_line
);
  initial serial_receive_line = 1'b1;
  // Bad stop is held low for BIT / 2 + 8 cycles, past mid-bit, then idle high
  task send(input [7:0] b, input stop_ok);
    integer i;
    begin
      serial_receive_line <= 1'b0;
      repeat (BIT) @(posedge sys_clk);
      for (i = 0; i < 8; i = i + 1)
      begin
        serial_receive_line <= b[i];
        repeat (BIT) @(posedge sys_clk);
      end
      serial_receive_line <= stop_ok;
      repeat (stop_ok ? BIT : BIT / 2 + 8) @(posedge sys_clk);
      serial_receive_line <= 1'b1;
    end
  endtask
  task get(output [7:0] b, output stop_seen);
    integer k;
    begin
      @(negedge serial_transmit_line);
      repeat (BIT / 2) @(posedge sys_clk);
      for (k = 0; k < 8; k = k + 1)
      begin
        repeat (BIT) @(posedge sys_clk);
        b[k] = serial_transmit_line;
      end
      repeat (BIT) @(posedge sys_clk);
      stop_seen = serial_transmit_line;
    end
  endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`include "uart_frac_regs.vh"
module tb;
  reg sys_clk;
  reg rst_b;
  reg [3:0] addr;
  reg [31:0] wdata;
  reg wr;
  reg rd;
  wire [31:0] rdata;
  wire serial_receive_line;
  wire serial_transmit_line;
  wire irq;
  integer error_cnt;
  integer checks_done;
  integer cycles = 0;
  reg [31:0] v;
  reg [7:0] b0;
  reg [7:0] b1;
  reg s0;
  reg s1;
  uart_frac uart_frac_i (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .serial_receive_line(serial_receive_line),
    .serial_transmit_line(serial_transmit_line),
    .irq(irq)
  );
  serial_peer serial_peer_i (
    .sys_clk(sys_clk),
    .serial_transmit_line(serial_transmit_line),
    .serial_receive_line(serial_receive_line)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task report_and_stop;
    begin
      if (error_cnt == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("wrong value %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task wr_reg(input [3:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [3:0] a, output [31:0] d);
    begin
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
    end
  endtask
  task t_reset;
    begin
      rd_reg(`A_CTL, v);
      chk("control", 32'h300, v);
      rd_reg(`A_IFLS, v);
      chk("thresholds", 32'h12, v);
      rd_reg(`A_FLAG, v);
      chk("flags", 32'h90, v);
      rd_reg(4'hf, v);
      chk("unmapped", 32'h0, v);
    end
  endtask
  task t_tx;
    begin
      wr_reg(`A_CTL, 32'h300);
      wr_reg(`A_IBRD, 32'h2);
      wr_reg(`A_FBRD, 32'h0);
      wr_reg(`A_LCRH, 32'h70);
      wr_reg(`A_CTL, 32'h301);
      fork
        begin
          serial_peer_i.get(b0, s0);
          serial_peer_i.get(b1, s1);
        end
        begin
          wr_reg(`A_DATA, 32'ha5);
          wr_reg(`A_DATA, 32'h5a);
          rd_reg(`A_FLAG, v);
          chk("busy", 32'h1, {31'h0, v[3]});
        end
      join
      chk("first char", 32'ha5, {24'h0, b0});
      chk("second char", 32'h5a, {24'h0, b1});
      chk("stop bit", 32'h1, {31'h0, s1});
      repeat (40) @(posedge sys_clk);
      rd_reg(`A_FLAG, v);
      chk("flags idle", 32'h90, v);
    end
  endtask
  task t_rx;
    begin
      wr_reg(`A_IM, 32'h8);
      serial_peer_i.send(8'h3c, 1'b1);
      repeat (40) @(posedge sys_clk);
      rd_reg(`A_DATA, v);
      chk("rx char", 32'h3c, v);
      serial_peer_i.send(8'hc3, 1'b0);
      repeat (40) @(posedge sys_clk);
      rd_reg(`A_RIS, v);
      chk("framing event", 32'h8, v & 32'h8);
      chk("irq", 32'h1, {31'h0, irq});
      rd_reg(`A_MIS, v);
      chk("masked status", 32'h8, v);
      rd_reg(`A_DATA, v);
      chk("errored char", 32'h1c3, v);
      wr_reg(`A_ICR, 32'h8);
      rd_reg(`A_RIS, v);
      chk("cleared event", 32'h0, v & 32'h8);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
  endtask
  task t_loop;
    begin
      wr_reg(`A_CTL, 32'h300);
      wr_reg(`A_LCRH, 32'h7e);
      wr_reg(`A_CTL, 32'h381);
      wr_reg(`A_DATA, 32'h69);
      repeat (400) @(posedge sys_clk);
      rd_reg(`A_DATA, v);
      chk("looped char", 32'h69, v);
    end
  endtask
  task t_ovr;
    begin
      wr_reg(`A_CTL, 32'h300);
      wr_reg(`A_LCRH, 32'h60);
      wr_reg(`A_IBRD, 32'h4);
      wr_reg(`A_CTL, 32'h301);
      serial_peer_i.send(8'h11, 1'b1);
      serial_peer_i.send(8'h22, 1'b1);
      repeat (1100) @(posedge sys_clk);
      rd_reg(`A_RIS, v);
      chk("timeout and overrun", 32'h44, v & 32'h44);
      rd_reg(`A_DATA, v);
      chk("held char", 32'h11, v);
      rd_reg(`A_RIS, v);
      chk("timeout cleared by read", 32'h0, v & 32'h4);
      serial_peer_i.send(8'h33, 1'b1);
      repeat (40) @(posedge sys_clk);
      rd_reg(`A_DATA, v);
      chk("char after overrun", 32'h833, v);
      rd_reg(`A_IBRD, v);
      chk("divisor readback", 32'h4, v);
    end
  endtask
  initial
  begin
    error_cnt = 0;
    checks_done = 0;
    rst_b = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_loop;
    t_ovr;
    report_and_stop;
  end
endmodule

// ==== tb/uart_frac_checker.sv ====
`timescale 1ns/1ns
`include "uart_frac_regs.vh"
module uart_frac_checker (
  input wire sys_clk,
  input wire rst_b,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire serial_receive_line,
  input wire serial_transmit_line,
  input wire irq
);
  reg [9:0] ctl_q;
  reg [5:0] ifls_q;
  reg [6:0] mask_q;
  // Shadow copies of written settings
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_q <= `CTL_RESET;
      ifls_q <= `IFLS_RESET;
      mask_q <= 7'h00;
    end
    else if (wr)
    begin
      if (addr == `A_CTL)
        ctl_q <= wdata[9:0];
      if (addr == `A_IFLS)
        ifls_q <= wdata[5:0];
      if (addr == `A_IM)
        mask_q <= wdata[6:0];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  AST_CTL_READ: assert property (rd && addr == `A_CTL |=>
    (rdata[9:0] & 10'h381) == ($past(ctl_q) & 10'h381)) else $error("control readback");
  AST_IFLS_READ: assert property (rd && addr == `A_IFLS |=>
    rdata[5:0] == $past(ifls_q)) else $error("threshold readback");
  AST_RDATA_IDLE: assert property (!rd |=> rdata == 32'h0)
    else $error("read data without read");
  AST_TX_RESET: assert property ($rose(rst_b) |-> serial_transmit_line)
    else $error("tx line not idle after reset");
  AST_IRQ_RESET: assert property ($rose(rst_b) |-> !irq)
    else $error("irq after reset");
  AST_START_MIN: assert property ($fell(serial_transmit_line) |->
    !serial_transmit_line [*8]) else $error("low bit too short");
  AST_HIGH_MIN: assert property ($rose(serial_transmit_line) |->
    serial_transmit_line [*8]) else $error("high bit too short");
  AST_IRQ_MASK: assert property (mask_q == 7'h00 && $past(mask_q) == 7'h00 |-> !irq)
    else $error("irq with all masked");
  AST_IRQ_MIS: assert property (rd && addr == `A_MIS |=>
    irq == (rdata[6:0] != 7'h00)) else $error("irq differs from masked status");
endmodule
bind uart_frac uart_frac_checker uart_frac_checker_i (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata(rdata),
  .serial_receive_line(serial_receive_line),
  .serial_transmit_line(serial_transmit_line),
  .irq(irq)
);
